// [hw/cp_ctrl.sv]
// Configuration pin controller: clear, wait, load, completion and pin release
`timescale 1ns/1ps
`default_nettype none
module cp_ctrl
  import cp_pkg::*;
#(
  parameter int         POWER_CYCLES    = 16,
  parameter int         CLEAR_CYCLES    = 64,
  parameter int         BCLK_HALF       = 2,
  parameter logic [2:0] CODE_MASTER_SER = 3'h0,
  parameter logic [2:0] CODE_MASTER_PAR = 3'h1,
  parameter logic [2:0] CODE_ASYNC_PER  = 3'h5,
  parameter logic [2:0] CODE_SYNC_PER   = 3'h3,
  parameter logic [2:0] CODE_EXPRESS    = 3'h2
) (
  // Clocks and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        cfg_bit_clock_in,
  // Configuration pins and serial data
  input  wire cp_pins_type pins_in,
  input  wire logic        ser_data_in,
  // Bitstream options and core handshakes
  input  wire cp_opt_type  opt_in,
  input  wire logic        load_finished_in,
  input  wire logic        byte_taken_in,
  input  wire logic        readback_sel_in,
  input  wire logic        scan_used_in,
  input  wire logic        scan_tdo_in,
  // Bit clock pin
  output logic             cfg_bit_clock_out,
  output logic             cfg_bit_clock_oe_out,
  // Init and completion pins, open drain
  output logic             init_n_out,
  output logic             init_n_oe_out,
  output logic             done_out,
  output logic             done_oe_out,
  output logic             done_pullup_out,
  // Peripheral status
  output logic             rdy_out,
  output logic             rdy_oe_out,
  output logic      [7:0]  data_out,
  output logic      [7:0]  data_oe_out,
  // PROM addressing
  output logic      [17:0] prom_addr_out,
  output logic             addr_strobe_out,
  output logic             prom_oe_out,
  // Pad control
  output logic             mode_pullup_out,
  output logic             hold_hiz_out,
  output logic             unused_io_cell_pullup_out,
  output logic             special_release_out,
  output logic             tdo_out,
  output logic             tdo_oe_out,
  // Core side
  output logic             global_init_out,
  output logic             io_active_out,
  output cp_mode_type      mode_out,
  output logic      [7:0]  cfg_byte_out,
  output logic             cfg_byte_valid_out,
  output logic             readback_step_out
);
  localparam logic [15:0] POWER_LAST = 16'(POWER_CYCLES - 1);
  localparam logic [15:0] CLEAR_LAST = 16'(CLEAR_CYCLES - 1);
  localparam logic [7:0]  BCLK_LAST  = 8'(BCLK_HALF - 1);

  // Elaboration checks on parameters
  if (CLEAR_CYCLES < 1 || CLEAR_CYCLES > 65535 || POWER_CYCLES < 1 ||
      POWER_CYCLES > 65535 || BCLK_HALF < 1 || BCLK_HALF > 256)
  begin : g_bad_count
    $error("cp_ctrl: count parameter out of range");
  end
  if (CODE_MASTER_SER == SLAVE_SER_CODE || CODE_MASTER_PAR == SLAVE_SER_CODE ||
      CODE_ASYNC_PER == SLAVE_SER_CODE || CODE_SYNC_PER == SLAVE_SER_CODE ||
      CODE_EXPRESS == SLAVE_SER_CODE)
  begin : g_bad_code
    $error("cp_ctrl: mode code collides with slave serial");
  end

  cp_state_type r;
  cp_state_type n;
  cp_pins_type  ps;
  logic [7:0]   link_bval;
  logic         link_tog;
  logic         tog_s;

  // Pad levels into the main domain
  cp_sync #(.WIDTH($bits(cp_pins_type))) u_pin_sync (
    .clk_in (clk_in),
    .d_in   (pins_in),
    .q_out  (ps)
  );

  // Serial shifter on the link clock
  cp_link u_link (
    .link_clk_in (cfg_bit_clock_in),
    .rst_in      (rst_in),
    .ser_data_in (ser_data_in),
    .bval_out    (link_bval),
    .tog_out     (link_tog)
  );

  // Byte toggle crossing; the byte holds for eight link clocks
  cp_sync #(.WIDTH(1)) u_tog_sync (
    .clk_in (clk_in),
    .d_in   (link_tog),
    .q_out  (tog_s)
  );

  // Mode pin decode
  function automatic cp_mode_type mode_of(input logic [2:0] code);
    if (code == SLAVE_SER_CODE)
      return MD_SLAVE_SER;
    else if (code == CODE_MASTER_SER)
      return MD_MASTER_SER;
    else if (code == CODE_MASTER_PAR)
      return MD_MASTER_PAR;
    else if (code == CODE_ASYNC_PER)
      return MD_ASYNC_PER;
    else if (code == CODE_SYNC_PER)
      return MD_SYNC_PER;
    else if (code == CODE_EXPRESS)
      return MD_EXPRESS;
    else
      return MD_RESERVED;
  endfunction

  // Modes in which the device makes the bit clock
  function automatic logic bclk_drives(input cp_mode_type m);
    return (m == MD_MASTER_SER) || (m == MD_MASTER_PAR) || (m == MD_ASYNC_PER);
  endfunction

  function automatic logic is_master(input cp_mode_type m);
    return (m == MD_MASTER_SER) || (m == MD_MASTER_PAR);
  endfunction

  function automatic logic is_periph(input cp_mode_type m);
    return (m == MD_ASYNC_PER) || (m == MD_SYNC_PER);
  endfunction

  // Next state of the whole controller
  always_comb
  begin
    logic sel;
    logic wr_act;
    logic link_edge;
    logic tick;
    sel = !ps.chip_sel_n && ps.chip_sel;
    wr_act = sel && !ps.wr_strobe_n;
    link_edge = tog_s != r.tog_prev;
    tick = opt_in.done_link_clk ? link_edge : 1'b1;
    n = r;
    n.bval_valid = 1'b0;
    n.rb_step = 1'b0;
    n.data_oe = 1'b0;
    n.tog_prev = tog_s;
    n.wr_prev = wr_act;
    n.tdo = scan_tdo_in;
    n.tdo_oe = scan_used_in;
    n.done_pullup = opt_in.done_pullup;
    // Free-running divider for the bit clock
    if (r.bclk_div == BCLK_LAST)
    begin
      n.bclk_div = '0;
      n.bclk = !r.bclk;
    end
    else
      n.bclk_div = r.bclk_div + 8'h1;
    case (r.st)
      ST_POWER:
      begin
        n.init_oe = 1'b1;
        n.cnt = r.cnt + 16'h1;
        if (r.cnt == POWER_LAST)
        begin
          n.st = ST_CLEAR;
          n.cnt = '0;
        end
      end
      ST_CLEAR:
      begin
        n.init_oe = 1'b1;
        if (!ps.clear_req_n)
          n.cnt = '0;
        else if (r.cnt == CLEAR_LAST)
        begin
          n.st = ST_WAIT;
          n.init_oe = 1'b0;
          n.cnt = '0;
        end
        else
          n.cnt = r.cnt + 16'h1;
      end
      ST_WAIT:
      begin
        // External low on init keeps the device here
        if (ps.init_n)
        begin
          n.mode = mode_of(ps.cfg_mode_pins);
          n.cnt = '0;
          n.addr = '0;
          n.settle = MP_SETTLE;
          n.rdy = 1'b1;
          n.st = is_master(n.mode) ? ST_DELAY : ST_LOAD;
        end
      end
      ST_DELAY:
      begin
        n.cnt = r.cnt + 16'h1;
        if (r.cnt == WAIT_LAST)
          n.st = ST_LOAD;
      end
      ST_LOAD:
      begin
        if (r.mode == MD_MASTER_PAR)
        begin
          // Strobe rises first, address moves one cycle later
          if (r.addr_strobe)
          begin
            n.addr_strobe = 1'b0;
            n.addr = r.addr + 18'h1;
            n.settle = MP_SETTLE;
          end
          else if (r.settle != 2'h0)
          begin
            n.settle = r.settle - 2'h1;
            if (r.settle == 2'h1)
            begin
              n.bval = ps.data;
              n.bval_valid = 1'b1;
            end
          end
          else if (byte_taken_in)
            n.addr_strobe = 1'b1;
        end
        else if (r.mode == MD_ASYNC_PER)
        begin
          // Write strobe overrides read; write wins over a take
          if (wr_act && !r.wr_prev)
          begin
            n.bval = ps.data;
            n.bval_valid = 1'b1;
            n.rdy = 1'b0;
          end
          else if (byte_taken_in)
            n.rdy = 1'b1;
          n.data_oe = sel && !ps.rd_strobe_n && !wr_act;
          n.data = {r.rdy, STATUS_LOW_BITS};
        end
        else if (link_edge)
        begin
          n.bval = link_bval;
          n.bval_valid = 1'b1;
          if (r.mode == MD_SYNC_PER)
            n.rdy = 1'b0;
        end
        else if (byte_taken_in)
          n.rdy = 1'b1;
        if (load_finished_in)
        begin
          n.st = ST_DONE;
          n.dly = '0;
          n.addr_strobe = 1'b0;
        end
      end
      ST_DONE:
      begin
        if (tick)
        begin
          if (r.dly == opt_in.done_delay)
          begin
            n.done_oe = 1'b0;
            n.st = ST_START;
          end
          else
            n.dly = r.dly + 4'h1;
        end
      end
      ST_START:
      begin
        if (!(opt_in.done_hold_en && !ps.done))
        begin
          n.glob_init = 1'b0;
          n.io_act = 1'b1;
          n.st = ST_USER;
        end
      end
      ST_USER:
        n.rb_step = readback_sel_in && link_edge;
      default:
        n.st = ST_POWER;
    endcase
    // Clear request restarts from anywhere
    if (!ps.clear_req_n)
    begin
      n.st = ST_CLEAR;
      n.cnt = '0;
      n.init_oe = 1'b1;
      n.done_oe = 1'b1;
      n.glob_init = 1'b1;
      n.io_act = 1'b0;
      n.addr_strobe = 1'b0;
      n.bval_valid = 1'b0;
      n.data_oe = 1'b0;
    end
    // Pin roles follow the phase
    n.bclk_oe = ((n.st == ST_LOAD) || (n.st == ST_DONE)) && bclk_drives(n.mode);
    n.rdy_oe = (n.st == ST_LOAD) && is_periph(n.mode);
    n.prom_oe = (n.st == ST_LOAD) && (n.mode == MD_MASTER_PAR);
    n.cfg_phase = n.st != ST_USER;
    n.user_phase = n.st == ST_USER;
  end

  // State register
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      r <= CP_RST;
    else
      r <= n;
  end

  // Outputs straight from the state register
  assign cfg_bit_clock_out         = r.bclk;
  assign cfg_bit_clock_oe_out      = r.bclk_oe;
  assign init_n_out                = 1'b0;                    // Open drain, pulls low only
  assign init_n_oe_out             = r.init_oe;
  assign done_out                  = 1'b0;                    // Open drain, pulls low only
  assign done_oe_out               = r.done_oe;
  assign done_pullup_out           = r.done_pullup;
  assign rdy_out                   = r.rdy;
  assign rdy_oe_out                = r.rdy_oe;
  assign data_out                  = r.data;
  assign data_oe_out               = {8{r.data_oe}};
  assign prom_addr_out             = r.addr;
  assign addr_strobe_out           = r.addr_strobe;
  assign prom_oe_out               = r.prom_oe;
  assign mode_pullup_out           = r.cfg_phase;
  assign hold_hiz_out              = r.cfg_phase;
  assign unused_io_cell_pullup_out = r.user_phase;
  assign special_release_out       = r.user_phase;
  assign tdo_out                   = r.tdo;
  assign tdo_oe_out                = r.tdo_oe;
  assign global_init_out           = r.glob_init;
  assign io_active_out             = r.io_act;
  assign mode_out                  = r.mode;
  assign cfg_byte_out              = r.bval;
  assign cfg_byte_valid_out        = r.bval_valid;
  assign readback_step_out         = r.rb_step;

  // Checks on the sequence and the pins
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  a_clear_restart: assert property (!ps.clear_req_n |=> r.st == ST_CLEAR && r.init_oe)
    else $error("clear request did not restart");
  a_clear_full: assert property ($rose(r.st == ST_WAIT) |->
      $past(r.st) == ST_CLEAR && $past(r.cnt) == CLEAR_LAST && !r.init_oe)
    else $error("wait entered before full clear");
  a_init_low: assert property ((r.st == ST_POWER || r.st == ST_CLEAR) |-> r.init_oe)
    else $error("init released while clearing");
  a_master_wait: assert property ((r.st == ST_DELAY ##1 r.st == ST_LOAD) |->
      $past(r.cnt) == WAIT_LAST)
    else $error("master wait too short");
  a_bclk_dir: assert property (r.st == ST_LOAD |-> r.bclk_oe == bclk_drives(r.mode))
    else $error("bit clock direction wrong");
  a_user_bclk: assert property (r.st == ST_USER |-> !r.bclk_oe && r.user_phase)
    else $error("bit clock driven after configuration");
  a_addr_strobe: assert property (($changed(r.addr) && $past(r.st) == ST_LOAD) |->
      $past(r.addr_strobe) && !r.addr_strobe)
    else $error("address moved without strobe");
  a_done_hold: assert property ((r.st == ST_START && opt_in.done_hold_en && !ps.done)
      |=> r.glob_init && !r.io_act)
    else $error("start-up not held by completion pin");
  a_rdy_write: assert property ((r.st == ST_LOAD && r.mode == MD_ASYNC_PER && !r.wr_prev
      && !ps.chip_sel_n && ps.chip_sel && !ps.wr_strobe_n && ps.clear_req_n)
      |=> !r.rdy && r.bval_valid)
    else $error("write did not mark busy");
  a_status_bit: assert property (r.data_oe |-> r.data[7] == $past(r.rdy)
      && r.data[6:0] == STATUS_LOW_BITS)
    else $error("status bit wrong");
  a_rdy_pull: assert property ((r.st == ST_POWER || r.st == ST_CLEAR || r.st == ST_WAIT)
      |-> !r.rdy_oe && r.cfg_phase)
    else $error("byte-ready driven before init high");
  a_done_rise: assert property ($fell(r.done_oe) |-> $past(r.st) == ST_DONE)
    else $error("completion released early");

  c_user: cover property (r.st == ST_START ##1 r.st == ST_USER);
  c_master: cover property (r.st == ST_DELAY ##1 r.st == ST_LOAD);
  c_status: cover property (r.data_oe);
  c_readback: cover property (r.rb_step);
endmodule
`default_nettype wire

// [hw/cp_link.sv]
// Serial byte assembly on the configuration bit clock
`timescale 1ns/1ps
`default_nettype none
module cp_link
  import cp_pkg::*;
(
  // Link clock and reset from the main domain
  input  wire logic       link_clk_in,
  input  wire logic       rst_in,
  // Serial data pin
  input  wire logic       ser_data_in,
  // Assembled byte and its toggle
  output logic      [7:0] bval_out,
  output logic            tog_out
);
  logic        rst_s;
  cp_link_type r;
  cp_link_type n;

  // Reset brought into the link domain; serial data already rides this clock,
  // so it is shifted directly and a frame completes on its own last edge
  cp_sync #(.WIDTH(1)) u_sync (
    .clk_in (link_clk_in),
    .d_in   (rst_in),
    .q_out  (rst_s)
  );

  // Shift MSB first, publish every eighth bit
  always_comb
  begin
    n = r;
    n.shift = {r.shift[6:0], ser_data_in};
    n.cnt = r.cnt + 3'h1;
    if (r.cnt == BIT_LAST)
    begin
      n.bval = {r.shift[6:0], ser_data_in};
      n.tog = !r.tog;
    end
  end

  always_ff @(posedge link_clk_in)
  begin
    if (rst_s)
      r <= '0;
    else
      r <= n;
  end

  assign bval_out = r.bval;
  assign tog_out  = r.tog;
endmodule
`default_nettype wire

// [hw/cp_pkg.sv]
// Shared types and constants for the configuration pin controller
package cp_pkg;

  // Clock rate and master-mode wait before loading starts
  localparam int CLK_PERIOD_NS = 40;
  localparam int WAIT_MIN_NS   = 50000;
  localparam int WAIT_MAX_NS   = 250000;
  localparam int WAIT_CYC      = (WAIT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [15:0] WAIT_LAST = 16'(WAIT_CYC - 1);

  // Mode pin code that selects slave serial (all pulled high)
  localparam logic [2:0] SLAVE_SER_CODE = 3'h7;
  // Low seven data bits driven high during a status read
  localparam logic [6:0] STATUS_LOW_BITS = 7'h7f;
  // Last bit index of a serial byte on the link
  localparam logic [2:0] BIT_LAST = 3'h7;
  // Cycles from an address change to sampling the synchronised data pins
  localparam logic [1:0] MP_SETTLE = 2'h3;

  // Controller sequence, Gray coded along the master-mode path through ST_DELAY
  typedef enum logic [2:0] {
    ST_POWER  = 3'h0,
    ST_CLEAR  = 3'h1,
    ST_WAIT   = 3'h3,
    ST_DELAY  = 3'h2,
    ST_LOAD   = 3'h6,
    ST_DONE   = 3'h7,
    ST_START  = 3'h5,
    ST_USER   = 3'h4
  } cp_fsm_type;

  // Configuration modes
  typedef enum logic [2:0] {
    MD_SLAVE_SER  = 3'h0,
    MD_MASTER_SER = 3'h1,
    MD_MASTER_PAR = 3'h2,
    MD_ASYNC_PER  = 3'h3,
    MD_SYNC_PER   = 3'h4,
    MD_EXPRESS    = 3'h5,
    MD_RESERVED   = 3'h6
  } cp_mode_type;

  // Configuration pins as seen at the pads
  typedef struct packed {
    logic       clear_req_n;
    logic       init_n;
    logic       done;
    logic       chip_sel_n;
    logic       chip_sel;
    logic       wr_strobe_n;
    logic       rd_strobe_n;
    logic [2:0] cfg_mode_pins;
    logic [7:0] data;
  } cp_pins_type;

  // Options carried in the bitstream
  typedef struct packed {
    logic       done_hold_en;
    logic       done_link_clk;
    logic [3:0] done_delay;
    logic       done_pullup;
  } cp_opt_type;

  // Whole state of the controller
  typedef struct packed {
    cp_fsm_type  st;
    cp_mode_type mode;
    logic [15:0] cnt;
    logic [3:0]  dly;
    logic [7:0]  bclk_div;
    logic        bclk;
    logic        bclk_oe;
    logic        init_oe;
    logic        done_oe;
    logic        rdy;
    logic        rdy_oe;
    logic [7:0]  data;
    logic        data_oe;
    logic [17:0] addr;
    logic        addr_strobe;
    logic        prom_oe;
    logic [1:0]  settle;
    logic [7:0]  bval;
    logic        bval_valid;
    logic        rb_step;
    logic        glob_init;
    logic        io_act;
    logic        tdo;
    logic        tdo_oe;
    logic        done_pullup;
    logic        wr_prev;
    logic        tog_prev;
    logic        cfg_phase;
    logic        user_phase;
  } cp_state_type;

  localparam cp_state_type CP_RST = '{st: ST_POWER, mode: MD_SLAVE_SER, init_oe: 1'b1,
                                      done_oe: 1'b1, rdy: 1'b1, glob_init: 1'b1,
                                      cfg_phase: 1'b1, default: '0};

  // Whole state of the link-side shifter
  typedef struct packed {
    logic [7:0] shift;
    logic [2:0] cnt;
    logic [7:0] bval;
    logic       tog;
  } cp_link_type;

endpackage

// [hw/cp_sync.sv]
// Two-flop synchroniser for a group of level signals
`timescale 1ns/1ps
`default_nettype none
module cp_sync #(
  parameter int WIDTH = 1
) (
  // Clock of the receiving domain
  input  wire logic             clk_in,
  // Asynchronous levels
  input  wire logic [WIDTH-1:0] d_in,
  // Synchronised levels
  output logic      [WIDTH-1:0] q_out
);
  logic [WIDTH-1:0] meta;

  // First stage feeds only the second
  always_ff @(posedge clk_in)
  begin
    meta  <= d_in;
    q_out <= meta;
  end
endmodule
`default_nettype wire

// [sim/cp_ctrl_bench.sv]
// Self-checking bench for the configuration pin controller
`timescale 1ns/1ps
`default_nettype none
module cp_ctrl_bench
  import cp_pkg::*;
;
  logic clk_in = 1'b0, rst_in = 1'b1, clr_n = 1'b1, ext_done = 1'b0, scan_used_in = 1'b0;
  logic load_finished_in = 1'b0, byte_taken_in = 1'b0;
  logic [2:0] m = 3'h7;
  int err_total = 0, checked = 0;
  logic cfg_bit_clock_out, cfg_bit_clock_oe_out, init_n_oe_out, done_oe_out, rdy_out;
  logic addr_strobe_out, prom_oe_out, mode_pullup_out, hold_hiz_out, tdo_oe_out;
  logic unused_io_cell_pullup_out, special_release_out, global_init_out, io_active_out;
  logic cfg_byte_valid_out, sel_n, wr_n, rd_n, hclk, hser;
  logic init_n_out, done_out, done_pullup_out, rdy_oe_out, tdo_out, readback_step_out;
  logic rb_sel = 1'b0, scan_tdo = 1'b0;
  logic [7:0] data_out, data_oe_out, cfg_byte_out, hdata;
  logic [17:0] prom_addr_out;
  cp_mode_type mode_out;
  cp_pins_type pins;
  localparam cp_opt_type OPT = '{1'b1, 1'b0, 4'h4, 1'b1};
  // Pad levels from all drivers and pull-ups
  assign pins = '{clr_n, !init_n_oe_out, !done_oe_out && !ext_done, sel_n, !sel_n,
                  wr_n, rd_n, m, (data_oe_out & data_out) | (~data_oe_out & hdata)};
  cp_ctrl #(.POWER_CYCLES(4), .CLEAR_CYCLES(8)) cp_ctrl_i (
    .clk_in, .rst_in, .cfg_bit_clock_in(cfg_bit_clock_oe_out ? cfg_bit_clock_out : hclk),
    .pins_in(pins), .ser_data_in(hser), .opt_in(OPT), .load_finished_in, .byte_taken_in,
    .readback_sel_in(rb_sel), .scan_used_in, .scan_tdo_in(scan_tdo), .cfg_bit_clock_out,
    .cfg_bit_clock_oe_out, .init_n_out, .init_n_oe_out, .done_out, .done_oe_out,
    .done_pullup_out, .rdy_out, .rdy_oe_out, .data_out, .data_oe_out, .prom_addr_out,
    .addr_strobe_out, .prom_oe_out, .mode_pullup_out, .hold_hiz_out,
    .unused_io_cell_pullup_out, .special_release_out, .tdo_out, .tdo_oe_out,
    .global_init_out, .io_active_out, .mode_out, .cfg_byte_out, .cfg_byte_valid_out,
    .readback_step_out);
  cp_host cp_host_i (.clk_in, .rdy_in(rdy_out), .addr_in(prom_addr_out),
    .prom_oe_in(prom_oe_out), .data_out(hdata), .sel_n_out(sel_n), .wr_n_out(wr_n),
    .rd_n_out(rd_n), .bclk_out(hclk), .ser_out(hser));
  // Main clock
  initial
    forever #20 clk_in = ~clk_in;
  task automatic finish_test();
    if (err_total == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cmp(input logic [17:0] got, input logic [17:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
  endtask
  // Bounded wait for a level, then compare
  task automatic wait_for(const ref logic s, input logic v, input int n);
    for (int i = 0; i < n; i++)
    begin
      #1;
      if (s === v)
        break;
      @(posedge clk_in);
    end
    cmp(s, v);
  endtask
  task automatic clear(input logic [2:0] code);
    @(posedge clk_in);
    m <= code;
    clr_n <= 1'b0;
    repeat (5) @(posedge clk_in);
    clr_n <= 1'b1;
    #1 cmp(init_n_oe_out, 1'b1);
    cmp(io_active_out, 1'b0);
    repeat (8) @(posedge clk_in);
    #1 cmp(init_n_oe_out, 1'b1);
    wait_for(init_n_oe_out, 1'b0, 20);
    repeat (6) @(posedge clk_in);
    #1;
  endtask
  task automatic t_reset();
    cmp(init_n_oe_out, 1'b1);
    cmp(done_oe_out, 1'b1);
    cmp(rdy_out, 1'b1);
    cmp(rdy_oe_out, 1'b0);
    cmp(init_n_out, 1'b0);
    cmp(done_out, 1'b0);
    cmp(hold_hiz_out, 1'b1);
    cmp(mode_pullup_out, 1'b1);
  endtask
  task automatic t_serial();
    clear(3'h7);
    cmp(mode_out, MD_SLAVE_SER);
    cmp(cfg_bit_clock_oe_out, 1'b0);
    cmp(rdy_oe_out, 1'b0);
    cp_host_i.send(8'ha7, 8);
    wait_for(cfg_byte_valid_out, 1'b1, 20);
    cmp(cfg_byte_out, 8'ha7);
  endtask
  task automatic t_done();
    @(posedge clk_in);
    ext_done <= 1'b1;
    scan_used_in <= 1'b1;
    scan_tdo <= 1'b1;
    load_finished_in <= 1'b1;
    @(posedge clk_in);
    load_finished_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    #1 cmp(done_oe_out, 1'b1);
    wait_for(done_oe_out, 1'b0, 8);
    repeat (6) @(posedge clk_in);
    #1 cmp(global_init_out, 1'b1);
    @(posedge clk_in);
    ext_done <= 1'b0;
    wait_for(global_init_out, 1'b0, 6);
    cmp(unused_io_cell_pullup_out, 1'b1);
    cmp(special_release_out, 1'b1);
    cmp(hold_hiz_out, 1'b0);
    cmp(tdo_oe_out, 1'b1);
    cmp(tdo_out, 1'b1);
    cmp(done_pullup_out, 1'b1);
    cmp(cfg_bit_clock_oe_out, 1'b0);
    @(posedge clk_in);
    rb_sel <= 1'b1;
    cp_host_i.send(8'h96, 8);
    wait_for(readback_step_out, 1'b1, 8);
  endtask
  // Synchronous peripheral: bytes on the external bit clock, byte-ready handshake
  task automatic t_sync();
    clear(3'h3);
    cmp(mode_out, MD_SYNC_PER);
    cmp(cfg_bit_clock_oe_out, 1'b0);
    cmp(rdy_oe_out, 1'b1);
    cp_host_i.send(8'hc5, 8);
    wait_for(cfg_byte_valid_out, 1'b1, 8);
    cmp(cfg_byte_out, 8'hc5);
    cmp(rdy_out, 1'b0);
    @(posedge clk_in);
    byte_taken_in <= 1'b1;
    @(posedge clk_in);
    byte_taken_in <= 1'b0;
    #1 cmp(rdy_out, 1'b1);
  endtask
  // Status read while selected
  task automatic rd(input logic [7:0] exp);
    fork
      cp_host_i.strobe(1'b0, 8'h00);
      begin
        repeat (5) @(posedge clk_in);
        #1 cmp(data_out, exp);
        cmp(data_oe_out, 8'hff);
      end
    join
  endtask
  task automatic t_async();
    clear(3'h5);
    cmp(mode_out, MD_ASYNC_PER);
    cmp(cfg_bit_clock_oe_out, 1'b1);
    cmp(rdy_oe_out, 1'b1);
    fork
      cp_host_i.strobe(1'b1, 8'h3c);
      wait_for(cfg_byte_valid_out, 1'b1, 8);
    join
    cmp(cfg_byte_out, 8'h3c);
    cmp(rdy_out, 1'b0);
    rd(8'h7f);
    @(posedge clk_in);
    byte_taken_in <= 1'b1;
    @(posedge clk_in);
    byte_taken_in <= 1'b0;
    #1 cmp(rdy_out, 1'b1);
    rd(8'hff);
  endtask
  task automatic t_master();
    clear(3'h1);
    repeat (1244) @(posedge clk_in);
    #1 cmp(cfg_bit_clock_oe_out, 1'b0);
    wait_for(cfg_bit_clock_oe_out, 1'b1, 6);
    wait_for(cfg_byte_valid_out, 1'b1, 200);
    cmp(prom_addr_out, 18'h0);
    cmp(prom_oe_out, 1'b1);
    cmp(cfg_byte_out, 8'h5a);
    cmp(mode_out, MD_MASTER_PAR);
    @(posedge clk_in);
    byte_taken_in <= 1'b1;
    @(posedge clk_in);
    byte_taken_in <= 1'b0;
    wait_for(addr_strobe_out, 1'b1, 4);
    cmp(prom_addr_out, 18'h0);
    @(posedge clk_in);
    #1 cmp(prom_addr_out, 18'h1);
  endtask
  // Reset with link clock edges, then the scenarios
  initial
  begin
    fork
      cp_host_i.send(8'h00, 4);
      repeat (6) @(posedge clk_in);
    join
    rst_in <= 1'b0;
    cp_host_i.send(8'h00, 2);
    t_reset();
    t_serial();
    t_done();
    t_sync();
    t_async();
    t_master();
    finish_test();
  end
  // Cuts a hung run short
  initial
  begin
    #300000;
    err_total++;
    finish_test();
  end
endmodule
`default_nettype wire

// [sim/cp_host.sv]
// Host processor and PROM model at the far side of the configuration pins
`timescale 1ns/1ps
`default_nettype none
module cp_host (
  // Device side
  input  wire logic        clk_in,
  input  wire logic        rdy_in,
  input  wire logic [17:0] addr_in,
  input  wire logic        prom_oe_in,
  // Host side pins
  output logic       [7:0] data_out,
  output logic             sel_n_out,
  output logic             wr_n_out,
  output logic             rd_n_out,
  output logic             bclk_out,
  output logic             ser_out
);
  logic [7:0] hd = 8'h00;
  // PROM answers its address; released host lines show the inverse
  assign data_out = prom_oe_in ? (addr_in[7:0] ^ 8'h5a) : hd;
  initial
    {sel_n_out, wr_n_out, rd_n_out, bclk_out, ser_out} = 5'h1c;
  // Serial bits msb first; the clock rests low between frames
  task automatic send(input logic [7:0] b, input int n);
    for (int i = n - 1; i >= 0; i--)
    begin
      ser_out = b[i];
      #16 bclk_out = 1'b1;
      #16 bclk_out = 1'b0;
    end
    ser_out = ~ser_out;
  endtask
  // Selected strobe held four clocks; a write first waits for byte-ready
  task automatic strobe(input logic wr, input logic [7:0] b);
    if (wr)
      wait (rdy_in === 1'b1);
    @(posedge clk_in);
    if (wr)
      hd <= b;
    sel_n_out <= 1'b0;
    wr_n_out <= !wr;
    rd_n_out <= wr;
    repeat (4) @(posedge clk_in);
    {sel_n_out, wr_n_out, rd_n_out} <= 3'h7;
    hd <= ~hd;
  endtask
endmodule
`default_nettype wire
